// [icc_channel.sv]
// One capture channel: edge detect, prescaler, four-deep FIFO, irq count
`timescale 1ns/10ps
`default_nettype none
module icc_channel (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        pin_sync,
  input  wire logic [15:0] ctrl,
  input  wire logic [15:0] type_b_timer_count,
  input  wire logic [15:0] type_c_timer_count,
  input  wire logic        idle_mode,
  input  wire logic        sleep_mode,
  input  wire logic        pop,
  output logic [15:0]      head_value,
  output logic             buffer_not_empty_flag,
  output logic             capture_overflow_flag,
  output logic             capture_irq,
  output logic             wake_event
);
  typedef struct packed {
    logic        pin_prev;
    logic [3:0]  presc;
    logic [1:0]  irq_cnt;
    logic [1:0]  rd_ptr;
    logic [1:0]  wr_ptr;
    logic [2:0]  level;
    logic        ovf;
    logic [63:0] mem;
  } icc_ch_state_t;

  icc_ch_state_t st_ff;
  icc_ch_state_t nxt_st;

  logic [2:0] mode;
  logic [1:0] cpi;
  logic       halted;
  logic       rise;
  logic       fall;
  logic       cap;
  logic [15:0] stamp;

  assign mode   = ctrl[icc_pkg::POS_MODE +: 3];
  assign cpi    = ctrl[icc_pkg::POS_CPI +: 2];
  assign halted = idle_mode & ctrl[icc_pkg::BIT_IDLE_STOP];
  assign rise   = pin_sync & ~st_ff.pin_prev;
  assign fall   = ~pin_sync & st_ff.pin_prev;
  assign stamp  = ctrl[icc_pkg::BIT_TIME_SEL] ? type_b_timer_count
                                              : type_c_timer_count;

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.pin_prev = pin_sync;
    cap             = 1'b0;
    capture_irq     = 1'b0;
    // wake-only mode, wake from sleep or idle
    wake_event = (mode == icc_pkg::MODE_WAKE) & rise
                 & (sleep_mode | idle_mode);
    if (!halted) begin
      case (mode)
        icc_pkg::MODE_EVERY: cap = rise | fall;
        icc_pkg::MODE_FALL:  cap = fall;
        icc_pkg::MODE_RISE:  cap = rise;
        icc_pkg::MODE_RISE4, icc_pkg::MODE_RISE16: begin
          if (rise) begin
            if (st_ff.presc == ((mode == icc_pkg::MODE_RISE4)
                ? icc_pkg::PRESC_4_LAST : icc_pkg::PRESC_16_LAST)) begin
              cap          = 1'b1;
              nxt_st.presc = 4'h0;
            end else begin
              nxt_st.presc = st_ff.presc + 4'h1;
            end
          end
        end
        default: cap = 1'b0;
      endcase
    end
    if (mode < icc_pkg::MODE_RISE4 || mode > icc_pkg::MODE_RISE16) begin
      nxt_st.presc = 4'h0;
    end
    if (mode == icc_pkg::MODE_OFF || mode == icc_pkg::MODE_UNUSED) begin
      nxt_st.irq_cnt = 2'h0;
    end
    if (pop && st_ff.level != 3'h0) begin
      nxt_st.rd_ptr = st_ff.rd_ptr + 2'h1;
      nxt_st.level  = nxt_st.level - 3'h1;
    end
    if (cap) begin
      if (st_ff.level == 3'(icc_pkg::FIFO_DEPTH)) begin
        nxt_st.ovf = 1'b1;
      end else begin
        nxt_st.mem[st_ff.wr_ptr*16 +: 16] = stamp;
        nxt_st.wr_ptr = st_ff.wr_ptr + 2'h1;
        nxt_st.level  = nxt_st.level + 3'h1;
      end
      if (mode == icc_pkg::MODE_EVERY) begin
        capture_irq = 1'b1;
      end else if (st_ff.irq_cnt == cpi) begin
        capture_irq    = 1'b1;
        nxt_st.irq_cnt = 2'h0;
      end else begin
        nxt_st.irq_cnt = st_ff.irq_cnt + 2'h1;
      end
    end
    if (nxt_st.level == 3'h0 && !cap) begin
      nxt_st.ovf = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign head_value            = st_ff.mem[st_ff.rd_ptr*16 +: 16];
  assign buffer_not_empty_flag = (st_ff.level != 3'h0);
  assign capture_overflow_flag = st_ff.ovf;
endmodule : icc_channel
`default_nettype wire

// [icc_chk.sv]
// Port checker for the two-channel capture block
`timescale 1ns/10ps
`default_nettype none
module icc_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [1:0]  capture_input_pin,
  input wire logic        idle_mode,
  input wire logic        sleep_mode,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        wake_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  AST_WAIT_TWO: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
    else $error("waitrequest not low in third cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest &&
    avs_address > 6'h14 |-> avs_response == 2'h2 && avs_readdata == 32'h0)
    else $error("unmapped read not refused");
  AST_MAPPED: assert property ((avs_read || avs_write) &&
    !avs_waitrequest && avs_address <= 6'h14 && avs_address[1:0] == 2'h0
    |-> avs_response == 2'h0)
    else $error("mapped access answered with error");
  // Read data must not drift between accesses
  AST_HOLD: assert property (!avs_read && !avs_write |=>
    $stable(avs_readdata) && $stable(avs_response))
    else $error("read data changed with no access");
  AST_WAKE_ONE: assert property (wake_request |=> !wake_request)
    else $error("wake pulse longer than one cycle");
  AST_WAKE_LP: assert property (wake_request |->
    $past(sleep_mode) || $past(idle_mode))
    else $error("wake outside sleep or idle");
  AST_WAKE_EDGE: assert property (wake_request |->
    $past(capture_input_pin, 6) != $past(capture_input_pin, 1))
    else $error("wake with no recent pin edge");
endmodule : icc_chk
bind icc_top icc_chk u_chk (.clk(clk), .reset(reset),
  .capture_input_pin(capture_input_pin), .idle_mode(idle_mode),
  .sleep_mode(sleep_mode), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .wake_request(wake_request));
`default_nettype wire

// [icc_pin_model.sv]
// External signal source that drives the two capture pins
`timescale 1ns/10ps
`default_nettype none
module icc_pin_model (
  input  wire logic       clk,
  output var logic [1:0]  capture_input_pin
);
  initial capture_input_pin = 2'h0;
  // Called right after a rising edge, so the level lands off the sample
  task automatic drive(input int ch, input logic lvl);
    capture_input_pin[ch] <= lvl;
  endtask : drive
endmodule : icc_pin_model
`default_nettype wire

// [icc_pkg.sv]
// Package of register map, field layout and timing constants for capture
`default_nettype none
package icc_pkg;
  localparam int          NUM_CH       = 2;
  localparam int          FIFO_DEPTH   = 4;
  localparam int          CNT_W        = 16;
  // Byte offsets, one aligned word each
  localparam logic [5:0]  OFS_CTRL0    = 6'h00;
  localparam logic [5:0]  OFS_CTRL1    = 6'h04;
  localparam logic [5:0]  OFS_BUF0     = 6'h08;
  localparam logic [5:0]  OFS_BUF1     = 6'h0c;
  localparam logic [5:0]  OFS_IRQ_STAT = 6'h10;
  localparam logic [5:0]  OFS_IRQ_MASK = 6'h14;
  // Control register field positions
  localparam int          BIT_IDLE_STOP = 13;
  localparam int          BIT_TIME_SEL  = 7;
  localparam int          POS_CPI       = 5;
  localparam int          BIT_OVF       = 4;
  localparam int          BIT_BNE       = 3;
  localparam int          POS_MODE      = 0;
  localparam logic [15:0] CTRL_WMASK    = 16'h20e7;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  // Mode codes
  localparam logic [2:0]  MODE_OFF      = 3'h0;
  localparam logic [2:0]  MODE_EVERY    = 3'h1;
  localparam logic [2:0]  MODE_FALL     = 3'h2;
  localparam logic [2:0]  MODE_RISE     = 3'h3;
  localparam logic [2:0]  MODE_RISE4    = 3'h4;
  localparam logic [2:0]  MODE_RISE16   = 3'h5;
  localparam logic [2:0]  MODE_UNUSED   = 3'h6;
  localparam logic [2:0]  MODE_WAKE     = 3'h7;
  localparam logic [3:0]  PRESC_4_LAST  = 4'h3;
  localparam logic [3:0]  PRESC_16_LAST = 4'hf;
  // Status bit layout: [1:0] capture interrupt, [3:2] wake
  localparam int          STAT_W        = 4;
  localparam logic [3:0]  STAT_RESET    = 4'h0;
  localparam logic [1:0]  WAIT_STATES   = 2'h1;
endpackage : icc_pkg
`default_nettype wire

// [icc_top.sv]
// Two-channel input capture block with Avalon-MM register slave
//
// Functional notes
// - Capture latches selected 16-bit timer count
// - Two independent channels, own pin, buffer
// - Select bit one picks type B timer
// - Modes 011 rise, 010 fall, 001 both
// - Modes 100 and 101 every 4th/16th rise
// - Codes 000 and 110 disable the channel
// - Mode 111 rising-edge wake interrupt only
// - Four-entry FIFO keeps arrival order
// - Interrupt after one to four captures
// - Every-edge mode interrupts on each capture
// - Overflow flag read-only, hardware set/clear
// - Not-empty flag tracks unread entries
// - Idle-stop bit halts channel in idle
// - Pin edge wakes from sleep and idle
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module icc_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  capture_input_pin,
  input  wire logic [15:0] type_b_timer_count,
  input  wire logic [15:0] type_c_timer_count,
  input  wire logic        idle_mode,
  input  wire logic        sleep_mode,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [1:0]       avs_response,
  output logic             irq,
  output logic             wake_request
);
  typedef struct packed {
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [15:0] ctrl0;
    logic [15:0] ctrl1;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic [1:0]  wait_cnt;
    logic        wait_rq;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic        irq;
    logic        wake;
    logic        waitreq;
  } icc_top_state_t;

  icc_top_state_t st_ff;
  icc_top_state_t nxt_st;

  logic [1:0]  pop;
  logic [15:0] head [2];
  logic [1:0]  bne;
  logic [1:0]  ovf;
  logic [1:0]  cap_irq;
  logic [1:0]  wake_ev;
  logic        access;
  logic        done;

  function automatic logic [15:0] ctrl_view(input logic [15:0] c,
                                            input logic o,
                                            input logic b);
    logic [15:0] v;
    v = c & icc_pkg::CTRL_WMASK;
    v[icc_pkg::BIT_OVF] = o;
    v[icc_pkg::BIT_BNE] = b;
    return v;
  endfunction : ctrl_view

  function automatic logic [15:0] ctrl_write(input logic [15:0] c,
                                             input logic [31:0] d,
                                             input logic [3:0] be);
    logic [15:0] v;
    v = c;
    if (be[0]) v[7:0] = d[7:0];
    if (be[1]) v[15:8] = d[15:8];
    return v & icc_pkg::CTRL_WMASK;
  endfunction : ctrl_write

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  // two independent channels
  icc_channel u_ch0 (
    .clk                   (clk),
    .reset                 (reset),
    .pin_sync              (st_ff.sync2[0]),
    .ctrl                  (st_ff.ctrl0),
    .type_b_timer_count    (type_b_timer_count),
    .type_c_timer_count    (type_c_timer_count),
    .idle_mode             (idle_mode),
    .sleep_mode            (sleep_mode),
    .pop                   (pop[0]),
    .head_value            (head[0]),
    .buffer_not_empty_flag (bne[0]),
    .capture_overflow_flag (ovf[0]),
    .capture_irq           (cap_irq[0]),
    .wake_event            (wake_ev[0])
  );

  icc_channel u_ch1 (
    .clk                   (clk),
    .reset                 (reset),
    .pin_sync              (st_ff.sync2[1]),
    .ctrl                  (st_ff.ctrl1),
    .type_b_timer_count    (type_b_timer_count),
    .type_c_timer_count    (type_c_timer_count),
    .idle_mode             (idle_mode),
    .sleep_mode            (sleep_mode),
    .pop                   (pop[1]),
    .head_value            (head[1]),
    .buffer_not_empty_flag (bne[1]),
    .capture_overflow_flag (ovf[1]),
    .capture_irq           (cap_irq[1]),
    .wake_event            (wake_ev[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and status
  // Answer comes after a fixed wait so read data is registered in time
  assign access = (avs_read | avs_write) & ~st_ff.wait_rq;
  assign done   = (avs_read | avs_write) & st_ff.wait_rq
                  & (st_ff.wait_cnt == icc_pkg::WAIT_STATES);
  assign pop[0] = done & avs_read & (avs_address == icc_pkg::OFS_BUF0);
  assign pop[1] = done & avs_read & (avs_address == icc_pkg::OFS_BUF1);

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = capture_input_pin;
    nxt_st.sync2 = st_ff.sync1;
    if (access) begin
      nxt_st.wait_rq  = 1'b1;
      nxt_st.wait_cnt = 2'h0;
      nxt_st.resp     = 2'h0;
      nxt_st.rdata    = 32'h0000_0000;
      case (avs_address)
        icc_pkg::OFS_CTRL0:
          nxt_st.rdata = {16'h0000, ctrl_view(st_ff.ctrl0, ovf[0], bne[0])};
        icc_pkg::OFS_CTRL1:
          nxt_st.rdata = {16'h0000, ctrl_view(st_ff.ctrl1, ovf[1], bne[1])};
        icc_pkg::OFS_BUF0:     nxt_st.rdata = {16'h0000, head[0]};
        icc_pkg::OFS_BUF1:     nxt_st.rdata = {16'h0000, head[1]};
        icc_pkg::OFS_IRQ_STAT: nxt_st.rdata = {28'h0000000, st_ff.stat};
        icc_pkg::OFS_IRQ_MASK: nxt_st.rdata = {28'h0000000, st_ff.mask};
        // Unmapped: slave error, read zero
        default:               nxt_st.resp  = 2'h2;
      endcase
    end else if (st_ff.wait_rq && !done) begin
      nxt_st.wait_cnt = st_ff.wait_cnt + 2'h1;
    end
    if (done) begin
      nxt_st.wait_rq = 1'b0;
      if (avs_write) begin
        case (avs_address)
          icc_pkg::OFS_CTRL0:
            nxt_st.ctrl0 = ctrl_write(st_ff.ctrl0, avs_writedata,
                                      avs_byteenable);
          icc_pkg::OFS_CTRL1:
            nxt_st.ctrl1 = ctrl_write(st_ff.ctrl1, avs_writedata,
                                      avs_byteenable);
          icc_pkg::OFS_IRQ_STAT:
            if (avs_byteenable[0]) begin
              nxt_st.stat = st_ff.stat & ~avs_writedata[3:0];
            end
          icc_pkg::OFS_IRQ_MASK:
            if (avs_byteenable[0]) begin
              nxt_st.mask = avs_writedata[3:0];
            end
          default: nxt_st.mask = nxt_st.mask;
        endcase
      end
    end
    // Set wins over a clear in the same cycle
    nxt_st.stat = nxt_st.stat | {wake_ev, cap_irq};
    nxt_st.irq  = |(nxt_st.stat & nxt_st.mask);
    // wake request leaves as a registered pulse
    nxt_st.wake = |wake_ev;
    // Registered so the bus sees waitrequest straight from a flop
    nxt_st.waitreq = ~(nxt_st.wait_rq
                       & (nxt_st.wait_cnt == icc_pkg::WAIT_STATES));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff       <= '0;
      st_ff.ctrl0 <= icc_pkg::CTRL_RESET;
      st_ff.ctrl1 <= icc_pkg::CTRL_RESET;
      st_ff.stat  <= icc_pkg::STAT_RESET;
      st_ff.mask  <= icc_pkg::STAT_RESET;
      st_ff.waitreq <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = st_ff.waitreq;
  assign avs_response    = st_ff.resp;
  assign irq             = st_ff.irq;
  assign wake_request    = st_ff.wake;
endmodule : icc_top
`default_nettype wire

// [input_capture_channel_tb_top.sv]
// Self-checking bench for the two-channel capture block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module input_capture_channel_tb_top;
  logic        clk, reset, idle, sleep, rd, wr, wreq, irq, wake;
  logic [1:0]  pin, resp, rsp;
  logic [15:0] tb_b, tb_c;
  logic [5:0]  addr;
  logic [31:0] wdata, rdata, v;
  int          n_mismatch, n_compared, cyc, n_wake;
  logic [15:0] q[2][$];
  logic [2:0]  mode_m[2];
  logic        sel_m[2], stop_m[2], ovf_m[2];
  int          pre[2];
  icc_pin_model u_pin (.clk(clk), .capture_input_pin(pin));
  icc_top dut (.clk(clk), .reset(reset), .capture_input_pin(pin),
    .type_b_timer_count(tb_b), .type_c_timer_count(tb_c), .idle_mode(idle),
    .sleep_mode(sleep), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .avs_response(resp), .irq(irq),
    .wake_request(wake));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) n_wake <= n_wake + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // Request held until waitrequest is sampled low at a rising edge; data
  // and response are taken at that edge, only the bench timeout ends a hang
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdata;
    rsp = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic set_ctrl(input int ch, input logic [15:0] c);
    bus(6'(ch * 4), 1'b1, {16'h0, c});
    mode_m[ch] = c[2:0];
    sel_m[ch] = c[7];
    stop_m[ch] = c[13];
    pre[ch] = 0;
  endtask : set_ctrl
  function automatic void m_edge(int ch, logic r, logic [15:0] vb,
                                 logic [15:0] vc);
    logic hit;
    if (idle && stop_m[ch]) return;
    hit = mode_m[ch] == 3'h1 || mode_m[ch] == {2'h1, r};
    if (r && mode_m[ch] inside {3'h4, 3'h5}) begin
      pre[ch]++;
      hit = pre[ch] == (mode_m[ch][0] ? 16 : 4);
      if (hit) pre[ch] = 0;
    end
    if (hit && q[ch].size() == 4) ovf_m[ch] = 1'b1;
    else if (hit) q[ch].push_back(sel_m[ch] ? vb : vc);
  endfunction : m_edge
  // Timers stay still around each pin edge so the captured count is exact
  task automatic pulse(input int ch);
    logic [15:0] vb, vc;
    for (int e = 1; e >= 0; e--) begin
      vb = 16'($urandom);
      vc = 16'($urandom);
      tb_b <= vb;
      tb_c <= vc;
      @(posedge clk);
      u_pin.drive(ch, e[0]);
      m_edge(ch, e[0], vb, vc);
      repeat (8) @(posedge clk);
    end
  endtask : pulse
  task automatic drain(input int ch);
    logic [15:0] h;
    bus(6'(ch * 4), 1'b0, 32'h0);
    `CHK("ovf", ovf_m[ch], v[4])
    `CHK("bne", q[ch].size() != 0, v[3])
    while (q[ch].size() != 0) begin
      bus(6'(8 + ch * 4), 1'b0, 32'h0);
      // Popped once here; the macro evaluates its expected value twice
      h = q[ch].pop_front();
      `CHK("buf", {16'h0, h}, v)
    end
    ovf_m[ch] = 1'b0;
    bus(6'(ch * 4), 1'b0, 32'h0);
    `CHK("flags", 2'h0, v[4:3])
  endtask : drain
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    reset = 1;
    {idle, sleep, rd, wr, n_mismatch, n_compared} = '0;
    ovf_m = '{1'b0, 1'b0};
    {tb_b, tb_c, addr, wdata} = '0;
    void'($urandom(80));
    repeat (16) @(posedge clk);
    reset <= 0;
    for (int a = 0; a < 24; a += 4) begin
      bus(6'(a), 1'b0, 32'h0);
      `CHK("reset", 32'h0, v)
    end
    bus(6'h3c, 1'b0, 32'h0);
    `CHK("unmapped", 34'h200000000, {rsp, v})
    set_ctrl(0, 16'hffff);
    bus(6'h00, 1'b0, 32'h0);
    `CHK("ctrl access", 32'h20e7, v)
    $display("test registers done");
    // modes 000 to 110 on both channels, timer choice alternating
    for (int ch = 0; ch < 2; ch++)
      for (int m = 0; m < 7; m++) begin
        set_ctrl(ch, {8'h0, ch[0] ^ m[0], 4'h0, 3'(m)});
        repeat (16) pulse(ch);
        drain(ch);
      end
    $display("test modes done");
    bus(6'h10, 1'b1, 32'hf);
    bus(6'h14, 1'b1, 32'h1);
    set_ctrl(0, 16'h0043);
    repeat (2) pulse(0);
    `CHK("irq early", 1'b0, irq)
    pulse(0);
    `CHK("irq third", 1'b1, irq)
    drain(0);
    bus(6'h10, 1'b1, 32'h1);
    bus(6'h10, 1'b0, 32'h0);
    `CHK("irq clear", 5'h00, {irq, v[3:0]})
    bus(6'h14, 1'b1, 32'h0);
    set_ctrl(0, 16'h0061);
    pulse(0);
    bus(6'h10, 1'b0, 32'h0);
    `CHK("every edge", 5'h01, {irq, v[3:0]})
    drain(0);
    $display("test interrupt done");
    idle <= 1'b1;
    set_ctrl(0, 16'h2003);
    set_ctrl(1, 16'h0003);
    pulse(0);
    pulse(1);
    idle <= 1'b0;
    drain(0);
    drain(1);
    $display("test idle done");
    bus(6'h10, 1'b1, 32'hf);
    sleep <= 1'b1;
    set_ctrl(1, 16'h0007);
    pulse(1);
    `CHK("wake pulse", 1, n_wake)
    bus(6'h10, 1'b0, 32'h0);
    `CHK("wake stat", 4'h8, v[3:0])
    sleep <= 1'b0;
    drain(1);
    $display("test wake done");
    report_and_stop();
  end
endmodule : input_capture_channel_tb_top
`default_nettype wire
